/* rtl/microstep_translator_pwm.v */
// Step translator, PWM current regulator and H-bridge gate logic.
// Assumes pins and comparator/sense inputs are asynchronous to clk.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "microstep_defines.vh"

module microstep_translator_pwm
#(
  parameter DEAD_CYC  = `DEAD_CYC,
  parameter TICK_CYC  = `PWM_TICK_CYC,
  parameter PWM_STEPS = `PWM_STEPS
)
(
  input  wire        clk,
  input  wire        rst,
  input  wire [2:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [15:0] rdata_q,
  input  wire        step_pulse_pin,
  input  wire        dir_pin,
  input  wire [1:0]  cur_above,
  input  wire [7:0]  desat_sense,
  input  wire [7:0]  rev_sense,
  output reg  [7:0]  gate_q,
  output wire        bridge_en_q,
  output wire        limit_en_q,
  output wire [1:0]  slope_trim_q,
  output reg  [10:0] coil_x_q,
  output reg  [10:0] coil_y_q,
  output reg  [7:0]  fault_q
);

  // ****************************************
  // Local states and widths
  // ****************************************
  localparam ST_OFF  = 2'h0;
  localparam ST_FWD  = 2'h1;
  localparam ST_SLOW = 2'h2;
  localparam ST_FAST = 2'h3;
  localparam SW      = 20;

  reg  [9:0]    ctrl_q;
  reg  [SW-1:0] s1_q;
  reg  [SW-1:0] s2_q;
  reg  [SW-1:0] s3_q;
  reg  [SW-1:0] flt_q;
  reg           step_prev_q;
  reg  [6:0]    pos_q;
  reg  [6:0]    pos_d;
  reg  [2:0]    mode_seen_q;
  reg  [10:0]   cx_d;
  reg  [10:0]   cy_d;
  reg  [7:0]    tick_cnt_q;
  reg  [7:0]    per_cnt_q;
  reg  [7:0]    lfsr_q;
  reg  [3:0]    st_q;
  reg  [3:0]    st_d;
  reg  [1:0]    fast_q;
  reg  [1:0]    fast_d;
  reg  [7:0]    want;
  reg  [7:0]    dead_q [0:3];
  integer       c;
  integer       h;
  integer       g;

  wire [SW-1:0] flt_d;
  wire [2:0]    mode;
  wire          step_now;
  wire          step_evt;
  wire          dir_up;
  wire          tick;
  wire          per_start;
  wire [7:0]    plen;
  wire          ctrl_wr;
  wire [1:0]    above;
  wire [7:0]    desat;
  wire [7:0]    rev;

  // ****************************************
  // Functions
  // ****************************************
  // Quarter sine in tenths of a percent, index 0..32
  function [9:0] mag;
    input [5:0] i;
    begin
      case (i)
        6'h00: mag = 10'h000;
        6'h01: mag = 10'h023;
        6'h02: mag = 10'h051;
        6'h03: mag = 10'h07f;
        6'h04: mag = 10'h0ae;
        6'h05: mag = 10'h0dd;
        6'h06: mag = 10'h10b;
        6'h07: mag = 10'h13a;
        6'h08: mag = 10'h15d;
        6'h09: mag = 10'h17f;
        6'h0a: mag = 10'h1ae;
        6'h0b: mag = 10'h1d1;
        6'h0c: mag = 10'h1f4;
        6'h0d: mag = 10'h222;
        6'h0e: mag = 10'h245;
        6'h0f: mag = 10'h268;
        6'h10: mag = 10'h28b;
        6'h11: mag = 10'h2ae;
        6'h12: mag = 10'h2d1;
        6'h13: mag = 10'h2f3;
        6'h14: mag = 10'h316;
        6'h15: mag = 10'h33a;
        6'h16: mag = 10'h351;
        6'h17: mag = 10'h368;
        6'h18: mag = 10'h37f;
        6'h19: mag = 10'h396;
        6'h1a: mag = 10'h3a2;
        6'h1b: mag = 10'h3ad;
        6'h1c: mag = 10'h3b9;
        6'h1d: mag = 10'h3c5;
        6'h1e: mag = 10'h3d1;
        6'h1f: mag = 10'h3dc;
        default: mag = 10'h3e8;
      endcase
    end
  endfunction

  // Signed setpoint for a table position; coil y uses position + 32
  function [10:0] setpt;
    input [6:0] p;
    input [2:0] m;
    reg   [5:0] i;
    reg   [9:0] a;
    begin
      i = p[5] ? (6'h20 - {1'b0, p[4:0]}) : {1'b0, p[4:0]};
      a = mag(i);
      if ((m == `MODE_HALF || m == `MODE_FULL) && a != 10'h000)
        a = 10'h3e8;
      setpt = p[6] ? (11'h000 - {1'b0, a}) : {1'b0, a};
    end
  endfunction

  // Position stride of each mode
  function [6:0] step_inc;
    input [2:0] m;
    begin
      case (m)
        3'h0: step_inc = 7'h01;
        3'h1: step_inc = 7'h02;
        3'h2: step_inc = 7'h04;
        3'h3: step_inc = 7'h08;
        3'h4: step_inc = 7'h10;
        `MODE_HALF: step_inc = 7'h10;
        `MODE_FULL: step_inc = 7'h20;
        default: step_inc = 7'h01;
      endcase
    end
  endfunction

  // Magnitude of a signed setpoint
  function [10:0] absv;
    input [10:0] v;
    begin
      absv = v[10] ? (11'h000 - v) : v;
    end
  endfunction

  // Half-bridge wants {a_hi, a_lo, b_hi, b_lo} for a coil state
  function [3:0] hb_want;
    input [1:0] st;
    input       neg;
    begin
      case (st)
        ST_FWD:  hb_want = neg ? 4'h6 : 4'h9;
        ST_FAST: hb_want = neg ? 4'h9 : 4'h6;
        ST_SLOW: hb_want = 4'h5;
        default: hb_want = 4'h0;
      endcase
    end
  endfunction

  // ****************************************
  // Register bus
  // ****************************************
  assign ctrl_wr      = wr_en && (addr == `ADDR_CTRL);
  assign mode         = ctrl_q[`CTRL_MODE +: 3];
  assign bridge_en_q  = ctrl_q[`CTRL_EN];
  assign limit_en_q   = ctrl_q[`CTRL_EN];
  assign slope_trim_q = ctrl_q[`CTRL_SLOPE +: 2];

  // Control register write and one-cycle read data
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q  <= `CTRL_RST;
      rdata_q <= 16'h0000;
    end
    else
    begin
      if (ctrl_wr)
        ctrl_q <= wdata[9:0];
      if (rd_en)
      begin
        case (addr)
          `ADDR_CTRL:  rdata_q <= {6'h00, ctrl_q};
          `ADDR_STAT:  rdata_q <= {fault_q, 1'b0, pos_q};
          `ADDR_COILX: rdata_q <= {{5{coil_x_q[10]}}, coil_x_q};
          `ADDR_COILY: rdata_q <= {{5{coil_y_q[10]}}, coil_y_q};
          default:     rdata_q <= 16'h0000;
        endcase
      end
      else
        rdata_q <= 16'h0000;
    end
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Three stages; a bit moves only when stages two and three agree
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q  <= {SW{1'b0}};
      s2_q  <= {SW{1'b0}};
      s3_q  <= {SW{1'b0}};
      flt_q <= {SW{1'b0}};
    end
    else
    begin
      s1_q  <= {rev_sense, desat_sense, cur_above, dir_pin, step_pulse_pin};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= flt_d;
    end
  end

  assign flt_d = (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & flt_q);
  assign above = flt_q[3:2];
  assign desat = flt_q[11:4];
  assign rev   = flt_q[19:12];

  // ****************************************
  // Step translator
  // ****************************************
  assign step_now = flt_q[0];
  assign step_evt = ctrl_q[`CTRL_POL] ? (step_prev_q & ~step_now)
                                      : (~step_prev_q & step_now);
  assign dir_up   = flt_q[1] ^ ctrl_q[`CTRL_SENSE];

  // Next position: a mode change outranks a step in the same cycle
  always @*
  begin
    pos_d = pos_q;
    if (mode != mode_seen_q)
      pos_d = (mode == `MODE_FULL) ? `FULL_START : `POS_RST;
    else if (step_evt)
    begin
      // 7-bit arithmetic wraps around the table by itself
      if (dir_up)
        pos_d = pos_q + step_inc(mode);
      else
        pos_d = pos_q - step_inc(mode);
    end
    cx_d = setpt(pos_d, mode);
    cy_d = setpt(pos_d + 7'h20, mode);
  end

  // Position and setpoints share one edge so no stale pair is seen
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pos_q       <= `POS_RST;
      mode_seen_q <= `MODE_RST;
      step_prev_q <= 1'b0;
      coil_x_q    <= 11'h000;
      coil_y_q    <= 11'h3e8;
    end
    else
    begin
      pos_q       <= pos_d;
      mode_seen_q <= mode;
      step_prev_q <= step_now;
      coil_x_q    <= cx_d;
      coil_y_q    <= cy_d;
    end
  end

  // ****************************************
  // PWM clock
  // ****************************************
  // Period is purely a tick count; supply and load never enter it
  assign tick      = (tick_cnt_q == 8'h00);
  assign per_start = tick && (per_cnt_q == 8'h00);
  assign plen      = (ctrl_q[`CTRL_DBL] ? PWM_STEPS[8:1] : PWM_STEPS[7:0])
                   + (ctrl_q[`CTRL_JIT] ? {6'h00, lfsr_q[1:0]} : 8'h00);

  // Tick prescaler, period counter and jitter source
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_q <= 8'h00;
      per_cnt_q  <= 8'h00;
      lfsr_q     <= `LFSR_SEED;
    end
    else
    begin
      if (tick_cnt_q >= TICK_CYC[7:0] - 8'h01)
        tick_cnt_q <= 8'h00;
      else
        tick_cnt_q <= tick_cnt_q + 8'h01;
      if (tick)
      begin
        if (per_cnt_q >= plen - 8'h01)
        begin
          per_cnt_q <= 8'h00;
          lfsr_q    <= {lfsr_q[6:0],
                        lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        end
        else
          per_cnt_q <= per_cnt_q + 8'h01;
      end
    end
  end

  // ****************************************
  // Current regulator
  // ****************************************
  // Per coil decay state; moves on a PWM tick, or to off in any cycle with enable low
  always @*
  begin
    st_d   = st_q;
    fast_d = fast_q;
    for (c = 0; c < 2; c = c + 1)
    begin
      // A drop in requested magnitude arms fast decay; the clear on leaving fast decay wins
      if (c == 0 && absv(cx_d) < absv(coil_x_q))
        fast_d[c] = 1'b1;
      if (c == 1 && absv(cy_d) < absv(coil_y_q))
        fast_d[c] = 1'b1;
      if (!ctrl_q[`CTRL_EN])
        st_d[2*c +: 2] = ST_OFF;
      else if (tick)
      begin
        case (st_q[2*c +: 2])
          ST_OFF:
            if (per_start)
              st_d[2*c +: 2] = ST_FWD;
          ST_FWD:
            // No time cap, so a weak supply gets a long duty
            if (above[c])
              st_d[2*c +: 2] = ST_SLOW;
          ST_SLOW:
            if (per_start && !above[c])
              st_d[2*c +: 2] = ST_FWD;
          ST_FAST:
            if (!above[c])
            begin
              st_d[2*c +: 2] = ST_FWD;
              fast_d[c] = 1'b0;
            end
          default:
            st_d[2*c +: 2] = ST_OFF;
        endcase
        if (fast_d[c] && st_d[2*c +: 2] != ST_OFF
            && st_q[2*c +: 2] != ST_FAST)
          st_d[2*c +: 2] = ST_FAST;
      end
    end
  end

  // Regulator state registers
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q   <= {ST_OFF, ST_OFF};
      fast_q <= 2'h0;
    end
    else
    begin
      st_q   <= st_d;
      fast_q <= fast_d;
    end
  end

  // ****************************************
  // Bridge gates
  // ****************************************
  // Wanted gate per switch: bit 2h+1 high side, bit 2h low side
  always @*
  begin
    want = {hb_want(st_q[3:2], coil_y_q[10]),
            hb_want(st_q[1:0], coil_x_q[10])};
    for (h = 0; h < 4; h = h + 1)
    begin
      // Active diode only where its partner is not wanted
      if (rev[2*h+1] && !want[2*h])
        want[2*h+1] = 1'b1;
      if (rev[2*h] && !want[2*h+1])
        want[2*h] = 1'b1;
    end
    want = want & ~fault_q;
    if (!ctrl_q[`CTRL_EN])
      want = 8'h00;
  end

  // Break before make: off first, then wait the dead time
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      gate_q <= 8'h00;
      for (g = 0; g < 4; g = g + 1)
        dead_q[g] <= 8'h00;
    end
    else
    begin
      // Own loop index; sharing one with the wanted-gate logic races
      for (g = 0; g < 4; g = g + 1)
      begin
        if (want[2*g +: 2] == gate_q[2*g +: 2])
          dead_q[g] <= 8'h00;
        else if (gate_q[2*g +: 2] != 2'h0)
        begin
          gate_q[2*g +: 2] <= 2'h0;
          dead_q[g] <= 8'h00;
        end
        else if (dead_q[g] >= DEAD_CYC[7:0])
        begin
          gate_q[2*g +: 2] <= want[2*g +: 2];
          dead_q[g] <= 8'h00;
        end
        else
          dead_q[g] <= dead_q[g] + 8'h01;
      end
    end
  end

  // Desaturation latches per switch; cleared by writing enable low
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      fault_q <= 8'h00;
    else
    begin
      if (ctrl_wr && !wdata[`CTRL_EN])
        fault_q <= desat & gate_q;
      else
        fault_q <= fault_q | (desat & gate_q);
    end
  end

endmodule // microstep_translator_pwm
`default_nettype wire

/* rtl/microstep_defines.vh */
// Constants for the microstep translator, PWM regulator and bridge gates.
// Assumes a 50 MHz clock; included by bare name from the design file.
`ifndef MICROSTEP_DEFINES_VH
`define MICROSTEP_DEFINES_VH

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ        50
`define DEAD_TIME_NS   200
`define DEAD_CYC       ((`DEAD_TIME_NS * `CLK_MHZ + 999) / 1000)
`define PWM_TICK_NS    320
`define PWM_TICK_CYC   ((`PWM_TICK_NS * `CLK_MHZ) / 1000)
`define PWM_STEPS      128

// ****************************************
// Register map and fields
// ****************************************
`define ADDR_CTRL      3'h0
`define ADDR_STAT      3'h1
`define ADDR_COILX     3'h2
`define ADDR_COILY     3'h3
`define CTRL_EN        0
`define CTRL_SLOPE     1
`define CTRL_MODE      3
`define CTRL_SENSE     6
`define CTRL_POL       7
`define CTRL_DBL       8
`define CTRL_JIT       9
`define CTRL_RST       10'h000

// ****************************************
// Translator and jitter seed
// ****************************************
`define MODE_HALF      3'h5
`define MODE_FULL      3'h6
`define FULL_START     7'h70
`define POS_RST        7'h00
`define MODE_RST       3'h0
`define LFSR_SEED      8'h01

`endif

/* verif/step_host.sv */
// Pin model of the host that drives the step and direction lines.
// Driven through its tasks by the bench; shares the bench clock.
`timescale 1ns/1ns
`default_nettype none
module step_host
(
  input  wire logic clk,
  output var  logic step_pulse_pin,
  output var  logic dir_pin
);
  // Long enough for the input filter and the direction set-up time
  localparam int HOLD = 30;

  // Lines idle low until the first command
  initial
  begin
    step_pulse_pin = 1'b0;
    dir_pin        = 1'b0;
  end

  // Direction settles before any step edge follows
  task automatic set_dir(input logic d);
    @(posedge clk);
    dir_pin <= d;
    repeat (HOLD) @(posedge clk);
  endtask

  // One pin level, held well past the minimum pulse width
  task automatic level(input logic v);
    @(posedge clk);
    step_pulse_pin <= v;
    repeat (HOLD) @(posedge clk);
  endtask
endmodule // step_host
`default_nettype wire

/* verif/microstep_translator_pwm_sva.sv */
// Port-level checker for the translator, regulator and gate logic.
// Bound to the top module; DEAD_CYC must match the instance.
`timescale 1ns/1ns
`default_nettype none
module microstep_translator_pwm_sva
#(
  parameter int DEAD_CYC = 2
)
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [2:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr_en,
  input wire logic        step_pulse_pin,
  input wire logic [7:0]  gate_q,
  input wire logic        bridge_en_q,
  input wire logic        limit_en_q,
  input wire logic [1:0]  slope_trim_q,
  input wire logic [10:0] coil_x_q,
  input wire logic [10:0] coil_y_q,
  input wire logic [7:0]  fault_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ****
  // Helper counters
  // ****
  logic       pin_q;
  logic [3:0] quiet_q;
  logic [3:0] gap_q;

  // Cycles since a step edge or ctrl write; cycles since high side 0 on
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_q   <= 1'b0;
      quiet_q <= 4'h0;
      gap_q   <= 4'hf;
    end
    else
    begin
      pin_q <= step_pulse_pin;
      if (pin_q != step_pulse_pin || (wr_en && addr == 3'h0))
        quiet_q <= 4'h0;
      else if (quiet_q != 4'hf)
        quiet_q <= quiet_q + 4'h1;
      if (gate_q[1])
        gap_q <= 4'h0;
      else if (gap_q != 4'hf)
        gap_q <= gap_q + 4'h1;
    end
  end

  // ****
  // Properties
  // ****
  property p_interlock;
    (gate_q & (gate_q >> 1) & 8'h55) == 8'h00;
  endproperty
  a_interlock: assert property (p_interlock)
    else $error("high and low switch on together");

  property p_dead_gap;
    $rose(gate_q[0]) |-> gap_q >= DEAD_CYC;
  endproperty
  a_dead_gap: assert property (p_dead_gap)
    else $error("low switch on before dead time");

  property p_off;
    (!bridge_en_q)[*2] |-> gate_q == 8'h00;
  endproperty
  a_off: assert property (p_off)
    else $error("gate on while bridges disabled");

  property p_en_write;
    wr_en && addr == 3'h0 |=> bridge_en_q == $past(wdata[0]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("enable bit not taken");

  property p_slope;
    wr_en && addr == 3'h0 |=> slope_trim_q == $past(wdata[2:1]);
  endproperty
  a_slope: assert property (p_slope)
    else $error("slope trim not taken");

  property p_limit;
    limit_en_q == bridge_en_q;
  endproperty
  a_limit: assert property (p_limit)
    else $error("limiter not armed with enable");

  property p_fault_off;
    (fault_q & $past(fault_q) & gate_q) == 8'h00;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("faulted switch still on");

  property p_coil_cause;
    $changed(coil_x_q) || $changed(coil_y_q) |-> quiet_q <= 4'h8;
  endproperty
  a_coil_cause: assert property (p_coil_cause)
    else $error("setpoint moved without a step");
endmodule // microstep_translator_pwm_sva
`default_nettype wire

/* verif/tb_microstep_translator_pwm.sv */
// Self-checking bench for the translator, regulator and gate logic.
// Top of the run; uses the host pin model and binds the checker.
`timescale 1ns/1ns
`default_nettype none
module tb_microstep_translator_pwm;
  logic        clk;
  logic        rst;
  logic [2:0]  addr;
  logic [15:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [1:0]  cur_above;
  logic [7:0]  desat_sense;
  logic [7:0]  rev_sense;
  wire  [15:0] rdata_q;
  wire         step_pulse_pin;
  wire         dir_pin;
  wire  [7:0]  gate_q;
  wire         bridge_en_q;
  wire         limit_en_q;
  wire  [1:0]  slope_trim_q;
  wire  [10:0] coil_x_q;
  wire  [10:0] coil_y_q;
  wire  [7:0]  fault_q;
  int          mismatches;
  int          checked;
  logic [15:0] rv;
  logic        sense;
  logic        pol;
  logic [15:0] tx [0:4] = '{16'h0023, 16'h0051, 16'h00ae, 16'h015d, 16'h028b};
  logic [15:0] ty [0:4] = '{16'h03dc, 16'h03d1, 16'h03b9, 16'h037f, 16'h028b};

  // Short dead time and PWM period keep the run brief
  microstep_translator_pwm #(.DEAD_CYC(2), .TICK_CYC(2), .PWM_STEPS(8)) DUT
  (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata_q(rdata_q), .step_pulse_pin(step_pulse_pin),
    .dir_pin(dir_pin), .cur_above(cur_above), .desat_sense(desat_sense),
    .rev_sense(rev_sense), .gate_q(gate_q), .bridge_en_q(bridge_en_q),
    .limit_en_q(limit_en_q), .slope_trim_q(slope_trim_q),
    .coil_x_q(coil_x_q), .coil_y_q(coil_y_q), .fault_q(fault_q)
  );

  step_host mdl
  (
    .clk(clk), .step_pulse_pin(step_pulse_pin), .dir_pin(dir_pin)
  );

  // 50 MHz clock
  always #10 clk = ~clk;

  // ****
  // Tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write taken at the second edge; outputs sampled mid-cycle after it
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(negedge clk);
  endtask

  // Gap first so a pending mode jump has landed before the read
  task automatic rd(input logic [2:0] a);
    repeat (3) @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    rv = rdata_q;
  endtask

  function automatic logic [15:0] sx(input logic [10:0] v);
    return {{5{v[10]}}, v};
  endfunction

  function automatic logic [15:0] ctl(input logic [2:0] m, input logic en);
    return {8'h00, pol, sense, m, 2'h1, en};
  endfunction

  // One full pulse, then position and both setpoints
  task automatic step(input logic up, input logic [6:0] p,
                      input logic [15:0] x, input logic [15:0] y);
    mdl.set_dir(up ^ sense);
    mdl.level(1'b1);
    mdl.level(1'b0);
    rd(3'h1);
    chk({9'h000, rv[6:0]}, {9'h000, p});
    chk(sx(coil_x_q), x);
    chk(sx(coil_y_q), y);
  endtask

  // Comparator and sense lines move together, just after an edge
  task automatic sense_in(input logic [1:0] ca, input logic [7:0] ds,
                          input logic [7:0] rs);
    @(posedge clk);
    cur_above   <= ca;
    desat_sense <= ds;
    rev_sense   <= rs;
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    #400000;
    mismatches++;
    close_out();
  end

  // ****
  // Tests
  // ****
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 3'h0;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    cur_above = 2'h0;
    desat_sense = 8'h00;
    rev_sense = 8'h00;
    sense = 1'b0;
    pol = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(3'h1);
    chk(rv, 16'h0000);
    chk(sx(coil_x_q), 16'h0000);
    chk(sx(coil_y_q), 16'h03e8);
    done("reset");
    for (int i = 0; i < 4; i++)
    begin
      wr(3'h0, {13'h0000, i[1:0], 1'b1});
      chk({14'h0000, slope_trim_q}, {14'h0000, i[1:0]});
      chk({15'h0000, bridge_en_q}, 16'h0001);
    end
    wr(3'h7, 16'h0000);
    rd(3'h0);
    chk(rv, 16'h0007);
    rd(3'h5);
    chk(rv, 16'h0000);
    // Every control bit, double and jitter too; upper bits read 0
    wr(3'h0, 16'hffff);
    rd(3'h0);
    chk(rv, 16'h03ff);
    done("registers");
    wr(3'h0, ctl(3'h0, 1'b0));
    step(1'b1, 7'h01, 16'h0023, 16'h03dc);
    step(1'b0, 7'h00, 16'h0000, 16'h03e8);
    step(1'b0, 7'h7f, 16'hffdd, 16'h03dc);
    sense = 1'b1;
    wr(3'h0, ctl(3'h0, 1'b0));
    step(1'b1, 7'h00, 16'h0000, 16'h03e8);
    done("direction");
    for (int m = 0; m < 5; m++)
    begin
      wr(3'h0, ctl(m[2:0], 1'b0));
      rd(3'h1);
      chk(rv, 16'h0000);
      step(1'b1, 7'h01 << m, tx[m], ty[m]);
    end
    wr(3'h0, ctl(3'h5, 1'b0));
    step(1'b1, 7'h10, 16'h03e8, 16'h03e8);
    step(1'b1, 7'h20, 16'h03e8, 16'h0000);
    wr(3'h0, ctl(3'h6, 1'b0));
    rd(3'h1);
    chk(rv, 16'h0070);
    step(1'b1, 7'h10, 16'h03e8, 16'h03e8);
    step(1'b0, 7'h70, 16'hfc18, 16'h03e8);
    done("modes");
    pol = 1'b1;
    wr(3'h0, ctl(3'h6, 1'b0));
    mdl.level(1'b1);
    rd(3'h1);
    chk(rv, 16'h0070);
    mdl.level(1'b0);
    rd(3'h1);
    chk(rv, 16'h0050);
    done("polarity");
    wr(3'h0, ctl(3'h6, 1'b1));
    for (int n = 0; n < 200 && gate_q == 8'h00; n++)
      @(posedge clk);
    chk({15'h0000, |gate_q}, 16'h0001);
    // Desaturation on a mixed set of switches, high and low sides
    sense_in(2'h3, 8'h5a, 8'h00);
    repeat (20) @(posedge clk);
    rd(3'h1);
    chk({15'h0000, |rv[15:8]}, 16'h0001);
    chk({8'h00, gate_q & fault_q}, 16'h0000);
    sense_in(2'h3, 8'h00, 8'h00);
    repeat (4) @(posedge clk);
    wr(3'h0, ctl(3'h6, 1'b0));
    sense_in(2'h3, 8'h00, 8'hff);
    repeat (20) @(posedge clk);
    chk({8'h00, fault_q}, 16'h0000);
    chk({8'h00, gate_q}, 16'h0000);
    done("bridge");
    // Coil x positive: forward 9, slow decay 5, fast decay 6 on gates 3:0
    sense_in(2'h0, 8'h00, 8'h00);
    wr(3'h0, ctl(3'h4, 1'b1));
    step(1'b1, 7'h10, 16'h028b, 16'h028b);
    chk({12'h000, gate_q[3:0]}, 16'h0009);
    sense_in(2'h1, 8'h00, 8'h00);
    step(1'b1, 7'h20, 16'h03e8, 16'h0000);
    chk({12'h000, gate_q[3:0]}, 16'h0005);
    step(1'b1, 7'h30, 16'h028b, 16'hfd75);
    chk({12'h000, gate_q[3:0]}, 16'h0006);
    sense_in(2'h0, 8'h00, 8'h00);
    repeat (40) @(posedge clk);
    chk({12'h000, gate_q[3:0]}, 16'h0009);
    done("regulator");
    // Reset in mid-run returns to 1/32 stepping at position zero
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(3'h1);
    chk(rv, 16'h0000);
    chk(sx(coil_y_q), 16'h03e8);
    rd(3'h0);
    chk(rv, 16'h0000);
    done("reset again");
    close_out();
  end
endmodule // tb_microstep_translator_pwm

bind microstep_translator_pwm microstep_translator_pwm_sva
  #(.DEAD_CYC(DEAD_CYC)) u_sva
(
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .step_pulse_pin(step_pulse_pin), .gate_q(gate_q),
  .bridge_en_q(bridge_en_q), .limit_en_q(limit_en_q),
  .slope_trim_q(slope_trim_q), .coil_x_q(coil_x_q),
  .coil_y_q(coil_y_q), .fault_q(fault_q)
);
`default_nettype wire
